/* hw/bst_cell.sv */
// bst_cell: one boundary scan cell, serial stage and parallel hold stage
// assumes: strobes arrive as one-cycle pulses on mclk
`default_nettype none
module bst_cell
    import bst_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic rst, // sync reset, high
    bst_ctl_if.reg_side sif, // scan strobes
    input wire logic cap_d, // value caught on capture
    input wire logic si, // serial in
    output logic so, // serial out
    output logic po // parallel hold output
);
    typedef struct packed {
        logic sh;
        logic upd;
    } bst_cell_st_t;
    bst_cell_st_t r, n;

    // hold stage is an update-enabled flop: a true latch would need a second clock tree
    always_comb begin
        n = r;
        if (sif.bsr_sel && sif.capture) begin
            n.sh = cap_d;
        end else if (sif.bsr_sel && sif.shift) begin
            n.sh = si;
        end
        if (sif.bsr_sel && sif.update) begin
            n.upd = r.sh;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign so = r.sh;
    assign po = r.upd;
endmodule
`default_nettype wire

/* hw/bst_ctl_if.sv */
// bst_ctl_if: scan strobes from the controller to the data registers
// assumes: strobes are single mclk pulses made by bst_tap_port
`default_nettype none
interface bst_ctl_if;
    logic capture;
    logic shift;
    logic update;
    logic bsr_sel;
    logic id_sel;
    logic tdi;
    modport ctl (output capture, shift, update, bsr_sel, id_sel, tdi);
    modport reg_side (input capture, shift, update, bsr_sel, id_sel, tdi);
endinterface
`default_nettype wire

/* hw/bst_idreg.sv */
// bst_idreg: device identification register, 32-bit capture and shift
// assumes: selected by the controller only while the identification opcode is active
`default_nettype none
module bst_idreg
    import bst_pkg::*;
#(
    parameter logic [3:0] VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] PART = 16'h5A5A, // arbitrary value
    parameter logic [3:0] CONT = 4'h2, // arbitrary value
    parameter logic [6:0] MFR = 7'h15 // arbitrary value
) (
    input wire logic mclk, // system clock
    input wire logic rst, // sync reset, high
    bst_ctl_if.reg_side sif, // scan strobes
    output logic so // serial out
);
    localparam logic [ID_W-1:0] ID_WORD = (ID_W'(VERSION) << ID_VER_LSB) | (ID_W'(PART) << ID_PART_LSB)
        | (ID_W'(CONT) << ID_CONT_LSB) | (ID_W'(MFR) << ID_MFR_LSB) | ID_W'(1);
    typedef struct packed {
        logic [ID_W-1:0] sh;
    } bst_id_st_t;
    bst_id_st_t r, n;

    always_comb begin
        n = r;
        if (sif.id_sel && sif.capture) begin
            n.sh = ID_WORD;
        end else if (sif.id_sel && sif.shift) begin
            n.sh = {sif.tdi, r.sh[ID_W-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r.sh <= ID_WORD;
        end else begin
            r <= n;
        end
    end

    assign so = r.sh[0];
endmodule
`default_nettype wire

/* hw/bst_pkg.sv */
// bst_pkg: constants, opcodes and controller states of the boundary scan test port
// assumes: compiled first; bst_cell, bst_idreg, bst_tap_port, bst_tap_chk and tb import it whole
`default_nettype none
package bst_pkg;
    localparam int IR_W = 16;
    localparam int ID_W = 32;
    localparam logic [15:0] OP_EXTEST = 16'hFFE8;
    localparam logic [15:0] OP_IDCODE = 16'hFFFE;
    localparam logic [15:0] OP_SAMPLE = 16'hFFF8;
    localparam logic [15:0] OP_HIGHZ = 16'hFFCF;
    localparam logic [15:0] OP_CLAMP = 16'hFFEF;
    localparam logic [15:0] OP_BYPASS = 16'hFFFF;
    localparam logic [15:0] IR_RESET = OP_IDCODE;
    localparam logic [15:0] IR_CAPTURE = 16'h0001;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_CONT_LSB = 8;
    localparam int ID_MFR_LSB = 1;
    localparam logic [2:0] ESC_CNT = 3'h5;
    // pin index inside the synchroniser vector
    localparam int P_TCK = 0;
    localparam int P_TMS = 1;
    localparam int P_TDI = 2;
    localparam int P_TRST = 3;
    // pad-cell levels: clock pulled low, others pulled high
    localparam logic [3:0] PIN_RESET = 4'hE;
    typedef enum logic [3:0] {
        S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR, S_EX2_DR,
        S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
    } bst_tap_t;
endpackage
`default_nettype wire

/* hw/bst_tap_port.sv */
// bst_tap_port: boundary scan test port, controller, instruction decode, scan chain
// assumes: test pins are asynchronous to mclk; tck well below mclk/6
`default_nettype none
module bst_tap_port
    import bst_pkg::*;
#(
    parameter int NP = 8 // digital pins covered by the chain
) (
    input wire logic mclk, // 40 MHz system clock
    input wire logic rst, // sync reset, high
    input wire logic tck, // test clock pin
    input wire logic tms, // test mode select pin
    input wire logic tdi, // test data in pin
    input wire logic trst_n, // test reset pin, low
    output logic tdo, // test data out
    output logic tdo_oe, // tdo driven when high
    input wire logic [NP-1:0] core_out, // core drive values
    input wire logic [NP-1:0] core_oe, // core drive enables
    output logic [NP-1:0] core_in, // pin levels to core
    input wire logic [NP-1:0] pad_in, // pin levels from pads
    output logic [NP-1:0] pad_out, // pad drive values
    output logic [NP-1:0] pad_oe // pad drive enables
);
    localparam int NC = 2 * NP;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] f;
        logic [NP-1:0] p1;
        logic [NP-1:0] p2;
        logic [NP-1:0] p3;
        logic [NP-1:0] pf;
        bst_tap_t st;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic byp;
        logic [2:0] esc;
        logic tdo;
        logic tdo_oe;
        logic [NP-1:0] pout;
        logic [NP-1:0] poe;
        logic [NP-1:0] cin;
    } bst_port_st_t;
    bst_port_st_t r, n;

    bst_ctl_if sif();
    logic [NC-1:0] cso;
    logic [NC-1:0] cpo;
    logic id_so;
    logic rise;
    logic fall;
    logic tms_v;
    logic tdi_v;
    logic test_mode;
    logic float_mode;
    logic dr_so;

    // ----------------------------------------
    // controller graph
    // ----------------------------------------
    function automatic bst_tap_t tap_next(input bst_tap_t s, input logic m);
        bst_tap_t t;
        t = s;
        unique case (s)
            S_TLR: t = m ? S_TLR : S_RTI;
            S_RTI: t = m ? S_SEL_DR : S_RTI;
            S_SEL_DR: t = m ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: t = m ? S_EX1_DR : S_SH_DR;
            S_SH_DR: t = m ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: t = m ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: t = m ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: t = m ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: t = m ? S_SEL_DR : S_RTI;
            S_SEL_IR: t = m ? S_TLR : S_CAP_IR;
            S_CAP_IR: t = m ? S_EX1_IR : S_SH_IR;
            S_SH_IR: t = m ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: t = m ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: t = m ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: t = m ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: t = m ? S_SEL_DR : S_RTI;
        endcase
        return t;
    endfunction

    // ----------------------------------------
    // pin sampling and edge finding
    // ----------------------------------------
    // a level counts only once stages two and three agree, so glitches never step the controller
    assign rise = ~r.f[P_TCK] & r.s2[P_TCK] & r.s3[P_TCK];
    assign fall = r.f[P_TCK] & ~r.s2[P_TCK] & ~r.s3[P_TCK];
    assign tms_v = (r.s2[P_TMS] == r.s3[P_TMS]) ? r.s3[P_TMS] : r.f[P_TMS];
    assign tdi_v = (r.s2[P_TDI] == r.s3[P_TDI]) ? r.s3[P_TDI] : r.f[P_TDI];

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    assign test_mode = (r.ir == OP_EXTEST) || (r.ir == OP_CLAMP);
    assign float_mode = (r.ir == OP_HIGHZ);
    assign sif.bsr_sel = (r.ir == OP_EXTEST) || (r.ir == OP_SAMPLE);
    assign sif.id_sel = (r.ir == OP_IDCODE);
    assign sif.capture = rise && (r.st == S_CAP_DR);
    assign sif.shift = rise && (r.st == S_SH_DR);
    assign sif.update = fall && (r.st == S_UPD_DR);
    assign sif.tdi = tdi_v;

    // unknown opcodes fall back to the bypass bit
    always_comb begin
        if (sif.id_sel) begin
            dr_so = id_so;
        end else if (sif.bsr_sel) begin
            dr_so = cso[NC-1];
        end else begin
            dr_so = r.byp;
        end
    end

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    bst_idreg u_id (
        .mclk(mclk),
        .rst(rst),
        .sif(sif),
        .so(id_so)
    );

    // cells 0..NP-1 watch pin levels, cells NP..NC-1 hold drive enables
    for (genvar k = 0; k < NC; k++) begin : g_cell
        logic cd;
        logic si;
        if (k < NP) begin : g_dat
            assign cd = r.pf[k];
        end else begin : g_en
            assign cd = core_oe[k-NP];
        end
        if (k == 0) begin : g_first
            assign si = tdi_v;
        end else begin : g_next
            assign si = cso[k-1];
        end
        bst_cell u_cell (
            .mclk(mclk),
            .rst(rst),
            .sif(sif),
            .cap_d(cd),
            .si(si),
            .so(cso[k]),
            .po(cpo[k])
        );
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.s1 = {trst_n, tdi, tms, tck};
        n.s2 = r.s1;
        n.s3 = r.s2;
        for (int i = 0; i < 4; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.f[i] = r.s3[i];
            end
        end
        n.p1 = pad_in;
        n.p2 = r.p1;
        n.p3 = r.p2;
        for (int i = 0; i < NP; i++) begin
            if (r.p2[i] == r.p3[i]) begin
                n.pf[i] = r.p3[i];
            end
        end

        if (rise) begin
            if (tms_v && tdi_v) begin
                n.esc = (r.esc == ESC_CNT) ? ESC_CNT : r.esc + 3'h1;
            end else begin
                n.esc = 3'h0;
            end
            n.st = tap_next(r.st, tms_v);
            if (n.esc == ESC_CNT) begin
                n.st = S_TLR;
            end
            unique case (r.st)
                S_CAP_IR: n.ir_sh = IR_CAPTURE;
                S_SH_IR: n.ir_sh = {tdi_v, r.ir_sh[IR_W-1:1]};
                S_CAP_DR: n.byp = 1'b0;
                S_SH_DR: n.byp = tdi_v;
                default: ;
            endcase
        end

        if (fall) begin
            if (r.st == S_UPD_IR) begin
                n.ir = r.ir_sh;
            end
            // tdo moves on the falling edge so the tester samples it stable late in the high phase
            if (r.st == S_SH_IR) begin
                n.tdo = r.ir_sh[0];
                n.tdo_oe = 1'b1;
            end else if (r.st == S_SH_DR) begin
                n.tdo = dr_so;
                n.tdo_oe = 1'b1;
            end else begin
                n.tdo_oe = 1'b0;
            end
        end

        if ((r.s2[P_TRST] == r.s3[P_TRST]) && !r.s3[P_TRST]) begin
            n.st = S_TLR;
            n.tdo_oe = 1'b0;
        end
        if (r.st == S_TLR) begin
            n.ir = IR_RESET;
        end

        if (float_mode) begin
            n.pout = core_out;
            n.poe = '0;
        end else if (test_mode) begin
            n.pout = cpo[NP-1:0];
            n.poe = cpo[NC-1:NP];
        end else begin
            n.pout = core_out;
            n.poe = core_oe;
        end
        n.cin = r.pf;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // pins reset to their pull levels: no tck edge, tms and tdi high
    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
            r.s1 <= PIN_RESET;
            r.s2 <= PIN_RESET;
            r.s3 <= PIN_RESET;
            r.f <= PIN_RESET;
            r.st <= S_TLR;
            r.ir <= IR_RESET;
        end else begin
            r <= n;
        end
    end

    assign tdo = r.tdo;
    assign tdo_oe = r.tdo_oe;
    assign core_in = r.cin;
    assign pad_out = r.pout;
    assign pad_oe = r.poe;
endmodule
`default_nettype wire

/* verif/bst_tap_chk.sv */
// bst_tap_chk: port-level assertions for the boundary scan test port
// assumes: bound into bst_tap_port; test pins move only on mclk falls, tck 4+4 mclk
`default_nettype none
module bst_tap_chk
    import bst_pkg::*;
#(
    parameter int NP = 8 // pins in chain
) (
    input wire logic mclk, // system clock
    input wire logic rst, // sync reset, high
    input wire logic tck, // test clock pin
    input wire logic tms, // test mode pin
    input wire logic tdi, // test data pin
    input wire logic trst_n, // test reset pin, low
    input wire logic tdo, // test data out
    input wire logic tdo_oe, // tdo enable
    input wire logic [NP-1:0] core_out, // core values
    input wire logic [NP-1:0] core_oe, // core enables
    input wire logic [NP-1:0] core_in, // levels to core
    input wire logic [NP-1:0] pad_in, // pad levels
    input wire logic [NP-1:0] pad_out, // pad values
    input wire logic [NP-1:0] pad_oe // pad enables
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // helper: cycles since reset, saturating
    // ------
    logic [2:0] up_r;
    logic [2:0] up_nxt;
    always_comb up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    always_ff @(posedge mclk) up_r <= rst ? 3'h0 : up_nxt;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_tdo_fall;
        $changed(tdo) |-> !$past(tck, 2);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved away from a tck fall");
    property p_oe_fall;
        $changed(tdo_oe) |-> !$past(tck, 2);
    endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("tdo_oe moved away from a tck fall");
    property p_oe_len;
        $rose(tdo_oe) |-> tdo_oe [*8];
    endproperty
    a_oe_len: assert property (p_oe_len) else $error("tdo_oe shorter than one shift period");
    property p_core_in;
        (up_r == 3'h7 && $stable(pad_in)) [*8] |-> core_in == pad_in;
    endproperty
    a_core_in: assert property (p_core_in) else $error("core_in does not follow pad_in");
    // shifting must never disturb the parallel stage
    property p_shift_hold;
        $past(tdo_oe) && tdo_oe |-> ($stable(pad_out) || pad_out == $past(core_out))
            && ($stable(pad_oe) || pad_oe == $past(core_oe));
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("pads moved during shift");
    property p_trst;
        (!trst_n) [*6] |-> !tdo_oe;
    endproperty
    a_trst: assert property (p_trst) else $error("tdo_oe high under test reset");
    property p_rst_vals;
        $fell(rst) |-> !tdo_oe && !tdo && pad_oe == '0 && pad_out == '0;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared by reset");
    property p_pad_fall;
        $changed(pad_out) && pad_out != $past(core_out) |-> !$past(tck, 2);
    endproperty
    a_pad_fall: assert property (p_pad_fall) else $error("test pad value moved off a tck fall");
endmodule
bind bst_tap_port bst_tap_chk #(.NP(NP)) bst_tap_chk_i (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
`default_nettype wire

/* verif/bst_tester.sv */
// bst_tester: behavioural test controller on the five test pins
// assumes: mclk 40 MHz; tck low and high four mclk each, a 200 ns period
`default_nettype none
module bst_tester (
    input wire logic mclk, // paces tck
    input wire logic tdo_w, // resolved test data out
    output var logic tck, // test clock
    output var logic tms, // test mode select
    output var logic tdi, // test data in
    output var logic trst_n // test reset, low
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // pin sequencing; tck stands low between frames
    // ------
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // tdo sampled late in the high phase, well after the fall update
    task automatic step(input logic m, input logic d, output logic o);
        repeat (2) @(negedge mclk);
        tms = m;
        tdi = d;
        repeat (2) @(negedge mclk);
        tck = 1'b1;
        repeat (4) @(negedge mclk);
        o = tdo_w;
        tck = 1'b0;
    endtask
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        step(1'b1, 1'b1, o);
        if (ir) begin
            step(1'b1, 1'b1, o);
        end
        repeat (2) step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
    task automatic escape();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
    task automatic pulse_trst();
        logic o;
        trst_n = 1'b0;
        repeat (8) @(negedge mclk);
        trst_n = 1'b1;
        step(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// tb: self-checking bench for the boundary scan test port
// assumes: bst_tester drives the test pins; the checker is bound separately
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb
    import bst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe;
    logic [7:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
    logic [31:0] d, r, c;
    logic [15:0] cel;
    logic [15:0] ops [4];
    int fail_count, checks_done, cyc, seed;
    wire tdo_w = tdo_oe ? tdo : 1'bz;
    bst_tap_port #(.NP(8)) bst_tap_port_i (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe));
    bst_tester bst_tester_i (.mclk(mclk), .tdo_w(tdo_w), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
    // ------
    // expectations and helpers
    // ------
    function automatic logic [31:0] exp_id();
        return {4'h1, 16'h5A5A, 4'h2, 7'h15, 1'b1};
    endfunction
    // cell 0 sits at tdi, the last enable cell at tdo
    function automatic logic [15:0] rev16(input logic [15:0] v);
        return {<<{v}};
    endfunction
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic ir(input logic [15:0] op);
        bst_tester_i.scan(1'b1, 16, {16'h0, op}, r);
        `CHK("ir_cap", 16'h0001, r[15:0])
    endtask
    task automatic id_chk();
        bst_tester_i.scan(1'b0, 32, 32'h0, d);
        c = exp_id();
        `CHK("id", c, d)
        `CHK("maker", c[6:1], d[6:1])
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        seed = 20;
        rst = 1'b1;
        core_out = 8'h00;
        core_oe = 8'h00;
        pad_in = 8'h00;
        ops = '{OP_BYPASS, OP_HIGHZ, OP_CLAMP, 16'h1234};
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK("oe_rst", 1'b0, tdo_oe)
        bst_tester_i.step(1'b0, 1'b1, d[0]);
        id_chk();
        pad_in = 8'($random(seed));
        core_oe = 8'($random(seed));
        core_out = 8'($random(seed));
        ir(OP_SAMPLE);
        bst_tester_i.scan(1'b0, 16, $random(seed), d);
        `CHK("sample_cap", rev16({core_oe, pad_in}), d[15:0])
        `CHK("core_in", pad_in, core_in)
        `CHK("pads_norm", {core_oe, core_out}, {pad_oe, pad_out})
        ir(OP_EXTEST);
        r = $random(seed);
        cel = rev16(r[15:0]);
        bst_tester_i.scan(1'b0, 16, r, d);
        `CHK("ext_cap", rev16({core_oe, pad_in}), d[15:0])
        core_out = ~core_out;
        repeat (4) @(negedge mclk);
        `CHK("ext_pads", cel, {pad_oe, pad_out})
        foreach (ops[k]) begin
            ir(ops[k]);
            core_out = 8'($random(seed));
            core_oe = 8'($random(seed));
            r = $random(seed);
            bst_tester_i.scan(1'b0, 8, r, d);
            `CHK("bypass", {r[6:0], 1'b0}, d[7:0])
            `CHK("oe", ops[k] == OP_HIGHZ ? 8'h00 : ops[k] == OP_CLAMP ? cel[15:8] : core_oe, pad_oe)
            if (ops[k] != OP_HIGHZ) begin
                `CHK("out", ops[k] == OP_CLAMP ? cel[7:0] : core_out, pad_out)
            end
        end
        // three ways back to the identification path
        for (int m = 0; m < 3; m++) begin
            ir(OP_BYPASS);
            if (m == 0) bst_tester_i.pulse_trst();
            else if (m == 1) bst_tester_i.escape();
            else begin
                rst = 1'b1;
                repeat (4) @(negedge mclk);
                rst = 1'b0;
                repeat (4) @(negedge mclk);
                bst_tester_i.step(1'b0, 1'b1, d[0]);
            end
            `CHK("oe_idle", 1'b0, tdo_oe)
            id_chk();
        end
        conclude();
    end
endmodule
`default_nettype wire
